// file: dewc_ctrl.sv
// Data EEPROM erase and write controller with page buffer and interrupt flags.
module dewc_ctrl
  import dewc_pkg::*;
#(
  parameter logic [TICK_W-1:0] EraseTicks = ERASE_TICKS,
  parameter logic [TICK_W-1:0] WriteTicks = WRITE_TICKS
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  // Register write strobes
  input  wire logic              addrWrite,
  input  wire logic [7:0]        addrWdata,
  input  wire logic              dataWrite,
  input  wire logic [7:0]        dataWdata,
  input  wire logic              ctrlWrite,
  input  wire logic [7:0]        ctrlWdata,
  // Register read-back
  output logic      [7:0]        nvmAddr,
  output logic      [7:0]        nvmData,
  output logic      [7:0]        nvmControl,
  output logic                   busy,
  // Slow timer clock
  input  wire logic              subClk,
  // Interrupt controls
  input  wire logic              nvmIrqEnable,
  input  wire logic              mfIrqEnable,
  input  wire logic              stackFull,
  input  wire logic              globalIrqSet,
  input  wire logic              globalIrqClear,
  input  wire logic              nvmIrqFlagClear,
  input  wire logic              irqAck,
  output logic                   nvmIrqFlag,
  output logic                   mfIrqFlag,
  output logic                   globalIrqEnable,
  output logic                   irqVector,
  // Array read-back
  input  wire logic [ADDR_W-1:0] readAddr,
  output logic      [7:0]        readData
);

  dewc_timer_if tmr ();

  dewc_cycle_timer u_timer (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .subClk  (subClk),
    .tmr     (tmr.timer)
  );

  logic [7:0]        mem [MEM_BYTES];
  logic [7:0]        pageBuf_reg [PAGE_BYTES];
  logic [7:0]        pageBuf_next [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] tag_reg, tag_next;

  dewc_state_t       state_reg, state_next;
  logic [ADDR_W-1:0] addr_reg, addr_next;
  logic [7:0]        data_reg, data_next;
  logic              mode_reg, mode_next;
  logic              wipeEn_reg, wipeEn_next;
  logic              wipeGo_reg, wipeGo_next;
  logic              progEn_reg, progEn_next;
  logic              progGo_reg, progGo_next;
  logic              pageFull_reg, pageFull_next;
  logic              closeWipe_reg, closeWipe_next;
  logic              nvmFlag_reg, nvmFlag_next;
  logic              mfFlag_reg, mfFlag_next;
  logic              gie_reg, gie_next;
  logic [7:0]        rd_reg, rd_next;
  logic              commitErase, commitPage, commitByte, bufClear;

  // Saturating in-page increment; the page bits are never touched.
  function automatic logic [ADDR_W-1:0] bump(input logic [ADDR_W-1:0] a);
    if (a[PAGE_W-1:0] == PAGE_LAST) begin
      bump = a; // RULE_05
    end else begin
      bump = {a[ADDR_W-1:PAGE_W], a[PAGE_W-1:0] + 4'h1}; // RULE_04
    end
  endfunction : bump

  always_comb begin
    state_next     = state_reg;
    addr_next      = addr_reg;
    data_next      = data_reg;
    mode_next      = mode_reg;
    wipeEn_next    = wipeEn_reg;
    wipeGo_next    = wipeGo_reg;
    progEn_next    = progEn_reg;
    progGo_next    = progGo_reg;
    pageFull_next  = pageFull_reg;
    closeWipe_next = closeWipe_reg;
    tag_next       = tag_reg;
    pageBuf_next   = pageBuf_reg;
    commitErase    = 1'b0;
    commitPage     = 1'b0;
    commitByte     = 1'b0;
    tmr.start      = 1'b0;
    tmr.length     = EraseTicks;
    case (state_reg)
      DEWC_IDLE: begin
        // Register changes during a cycle are ignored so a running cycle stays coherent.
        if (addrWrite) begin
          addr_next     = addrWdata[ADDR_W-1:0]; // RULE_24
          pageFull_next = 1'b0;
        end
        if (dataWrite) begin
          data_next = dataWdata;
          if (mode_reg && !pageFull_reg) begin // RULE_19
            pageBuf_next[addr_reg[PAGE_W-1:0]] = dataWdata; // RULE_18
            tag_next[addr_reg[PAGE_W-1:0]]     = 1'b1; // RULE_06
            if (addr_reg[PAGE_W-1:0] == PAGE_LAST) begin
              pageFull_next = 1'b1;
            end
            addr_next = bump(addr_reg);
          end
        end
        if (ctrlWrite) begin
          mode_next   = ctrlWdata[CTL_MODE];
          wipeEn_next = ctrlWdata[CTL_WIPE_ENABLE];
          progEn_next = ctrlWdata[CTL_PROGRAM_ENABLE];
          wipeGo_next = ctrlWdata[CTL_ER] & wipeEn_reg; // RULE_23
          progGo_next = ctrlWdata[CTL_WR] & progEn_reg; // RULE_13
          if (ctrlWdata[CTL_ER] && wipeEn_reg) begin
            closeWipe_next = 1'b1;
            tmr.start      = 1'b1;
            tmr.length     = EraseTicks;
            state_next     = DEWC_ERASE; // RULE_01
          end else if (ctrlWdata[CTL_WR] && progEn_reg) begin
            closeWipe_next = 1'b0;
            tmr.start      = 1'b1;
            if (mode_reg) begin
              tmr.length = WriteTicks;
              state_next = DEWC_PROG;
            end else begin
              tmr.length = EraseTicks;
              state_next = DEWC_BERASE; // RULE_15
            end
          end
        end
      end
      DEWC_ERASE: begin
        if (tmr.done) begin // RULE_25
          commitErase = 1'b1;
          wipeGo_next = 1'b0; // RULE_10
          state_next  = DEWC_CLOSE;
        end
      end
      DEWC_BERASE: begin
        if (tmr.done) begin
          tmr.start  = 1'b1;
          tmr.length = WriteTicks;
          state_next = DEWC_PROG;
        end
      end
      DEWC_PROG: begin
        if (tmr.done) begin
          commitPage  = mode_reg;
          commitByte  = ~mode_reg;
          progGo_next = 1'b0; // RULE_14
          state_next  = DEWC_CLOSE;
        end
      end
      DEWC_CLOSE: begin
        if (closeWipe_reg) begin
          wipeEn_next = 1'b0; // RULE_10
        end else begin
          progEn_next = 1'b0; // RULE_14
        end
        state_next = DEWC_IDLE;
      end
      default: begin
        state_next = DEWC_IDLE;
      end
    endcase
    bufClear = (wipeEn_reg & ~wipeEn_next) | (progEn_reg & ~progEn_next); // RULE_03 RULE_17
    if (bufClear) begin
      tag_next = '0;
      for (int i = 0; i < PAGE_BYTES; i++) begin
        pageBuf_next[i] = 8'h00;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_reg     <= DEWC_IDLE;
      addr_reg      <= ADDR_RST[ADDR_W-1:0];
      data_reg      <= DATA_RST;
      mode_reg      <= 1'b0;
      wipeEn_reg    <= 1'b0;
      wipeGo_reg    <= 1'b0;
      progEn_reg    <= 1'b0;
      progGo_reg    <= 1'b0;
      pageFull_reg  <= 1'b0;
      closeWipe_reg <= 1'b0;
      tag_reg       <= '0; // RULE_02
      for (int i = 0; i < PAGE_BYTES; i++) begin
        pageBuf_reg[i] <= 8'h00; // RULE_02
      end
    end else begin
      state_reg     <= state_next;
      addr_reg      <= addr_next;
      data_reg      <= data_next;
      mode_reg      <= mode_next;
      wipeEn_reg    <= wipeEn_next;
      wipeGo_reg    <= wipeGo_next;
      progEn_reg    <= progEn_next;
      progGo_reg    <= progGo_next;
      pageFull_reg  <= pageFull_next;
      closeWipe_reg <= closeWipe_next;
      tag_reg       <= tag_next;
      pageBuf_reg   <= pageBuf_next;
    end
  end

  // The array is non-volatile, so it takes no reset.
  always_ff @(posedge clk_sys) begin
    for (int i = 0; i < PAGE_BYTES; i++) begin
      if (commitErase && tag_reg[i]) begin
        mem[{addr_reg[ADDR_W-1:PAGE_W], 4'(i)}] <= ERASED_VALUE; // RULE_11
      end
      if (commitPage && tag_reg[i]) begin
        mem[{addr_reg[ADDR_W-1:PAGE_W], 4'(i)}] <= pageBuf_reg[i];
      end
    end
    if (commitByte) begin
      mem[addr_reg] <= data_reg;
    end
  end

  // Interrupt flags: a hardware set wins over a clear in the same cycle.
  always_comb begin
    nvmFlag_next = (state_reg == DEWC_CLOSE) | (nvmFlag_reg & ~nvmIrqFlagClear); // RULE_20
    mfFlag_next  = (state_reg == DEWC_CLOSE) | (mfFlag_reg & ~irqAck); // RULE_22
    gie_next     = gie_reg;
    if (irqAck || globalIrqClear) begin
      gie_next = 1'b0; // RULE_22
    end
    if (globalIrqSet) begin
      gie_next = 1'b1;
    end
    rd_next = mem[readAddr];
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      nvmFlag_reg <= 1'b0;
      mfFlag_reg  <= 1'b0;
      gie_reg     <= 1'b0;
      rd_reg      <= 8'h00;
    end else begin
      nvmFlag_reg <= nvmFlag_next;
      mfFlag_reg  <= mfFlag_next;
      gie_reg     <= gie_next;
      rd_reg      <= rd_next;
    end
  end

  assign nvmAddr         = {1'b0, addr_reg}; // RULE_24
  assign nvmData         = data_reg;
  assign nvmControl      = {1'b0, wipeEn_reg, wipeGo_reg, mode_reg,
                            progEn_reg, progGo_reg, 2'b00};
  assign busy            = (state_reg != DEWC_IDLE);
  assign nvmIrqFlag      = nvmFlag_reg;
  assign mfIrqFlag       = mfFlag_reg;
  assign globalIrqEnable = gie_reg;
  assign irqVector       = gie_reg & nvmIrqEnable & mfIrqEnable & mfFlag_reg
                           & ~stackFull; // RULE_21
  assign readData        = rd_reg;

endmodule : dewc_ctrl

// file: dewc_pkg.sv
// Shared constants and types for the data EEPROM erase and write controller.
// What this block does and what software must do
// [RULE_01] Page mode erase works on one 16-byte page at a time.
// [RULE_02] Power-on reset empties the internal page buffer.
// [RULE_03] wipe_enable falling clears the page buffer; rising leaves it alone.
// [RULE_04] Page erase data writes bump the low 4 address bits, never the page bits.
// [RULE_05] In-page address stops at 0FH and never wraps.
// [RULE_06] Each erase-setup data write tags the current address for erasure.
// [RULE_07] Software sets wipe_enable, then wipe_trigger in the very next instruction.
// [RULE_08] Software should mask global interrupts around cycle activation.
// [RULE_09] Cycle lengths come from a timer asynchronous to the system clock.
// [RULE_10] Erase end clears wipe_trigger first, then wipe_enable.
// [RULE_11] Erased page locations read back as zero.
// [RULE_12] Byte write: load address and data, set program_enable, then program_go.
// [RULE_13] program_go without program_enable starts nothing.
// [RULE_14] Write end clears program_go first, then program_enable.
// [RULE_15] A byte write erases the target byte before programming it.
// [RULE_16] Software erases a page before page-writing it.
// [RULE_17] program_enable falling clears the page buffer; rising does not.
// [RULE_18] Page write data goes to the buffer at the in-page address, then increments.
// [RULE_19] Page write data after the address saturates is ignored.
// [RULE_20] Every cycle end sets nvm_irq_flag and the multi-function flag.
// [RULE_21] Vector only with all three enables set and the stack not full.
// [RULE_22] Servicing clears only the multi-function flag and global enable.
// [RULE_23] wipe_trigger without wipe_enable has no effect.
// [RULE_24] Address register holds 7 bits; bit 7 reads zero.
// [RULE_25] Busy holds until the synchronised timer completion arrives.
package dewc_pkg;

  localparam int ADDR_W     = 7;
  localparam int PAGE_W     = 4;
  localparam int PAGE_BYTES = 16;
  localparam int MEM_BYTES  = 128;
  localparam int TICK_W     = 8;

  localparam int CTL_WIPE_ENABLE = 6;
  localparam int CTL_ER   = 5;
  localparam int CTL_MODE = 4;
  localparam int CTL_PROGRAM_ENABLE = 3;
  localparam int CTL_WR   = 2;

  localparam logic [7:0]        ADDR_RST     = 8'h00;
  localparam logic [7:0]        DATA_RST     = 8'h00;
  localparam logic [7:0]        ERASED_VALUE = 8'h00;
  localparam logic [PAGE_W-1:0] PAGE_LAST    = 4'hF;

  // Cycle lengths in ticks of the slow asynchronous timer clock.
  localparam logic [TICK_W-1:0] ERASE_TICKS = 8'h04;
  localparam logic [TICK_W-1:0] WRITE_TICKS = 8'h04;

  typedef enum logic [2:0] {
    DEWC_IDLE,
    DEWC_ERASE,
    DEWC_BERASE,
    DEWC_PROG,
    DEWC_CLOSE
  } dewc_state_t;

endpackage : dewc_pkg

// file: dewc_timer_if.sv
// Start and completion handshake between the controller and its cycle timer.
interface dewc_timer_if;
  import dewc_pkg::*;
  logic              start;
  logic [TICK_W-1:0] length;
  logic              done;
  modport ctrl  (output start, output length, input done);
  modport timer (input start, input length, output done);
endinterface : dewc_timer_if

// file: dewc_cycle_timer.sv
// Cycle timer counting ticks of the asynchronous slow clock.
module dewc_cycle_timer
  import dewc_pkg::*;
(
  // System clock and reset
  input  wire logic   clk_sys,
  input  wire logic   reset_n,
  // Slow timer clock, asynchronous to clk_sys
  input  wire logic   subClk,
  // Handshake with the controller
  dewc_timer_if.timer tmr
);

  logic              sync1_reg, sync2_reg, sync3_reg;
  logic [TICK_W-1:0] cnt_reg, cnt_next;
  logic              run_reg, run_next;
  logic              done_reg, done_next;
  logic              tick;

  // Only the second stage reads the first; the edge is taken after stage two.
  assign tick     = sync2_reg & ~sync3_reg; // RULE_25
  assign tmr.done = done_reg;

  always_comb begin
    cnt_next  = cnt_reg;
    run_next  = run_reg;
    done_next = 1'b0;
    if (tmr.start) begin
      cnt_next = tmr.length;
      run_next = 1'b1;
    end else if (run_reg && tick) begin // RULE_09
      if (cnt_reg <= 8'h01) begin
        run_next  = 1'b0;
        done_next = 1'b1;
      end else begin
        cnt_next = cnt_reg - 8'h01;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
      cnt_reg   <= '0;
      run_reg   <= 1'b0;
      done_reg  <= 1'b0;
    end else begin
      sync1_reg <= subClk;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      cnt_reg   <= cnt_next;
      run_reg   <= run_next;
      done_reg  <= done_next;
    end
  end

endmodule : dewc_cycle_timer

// file: dewc_ctrl_props.sv
// Concurrent checks on the ports of the erase and write controller.
module dewc_ctrl_props
  import dewc_pkg::*;
#(
  parameter logic [TICK_W-1:0] EraseTicks = ERASE_TICKS,
  parameter logic [TICK_W-1:0] WriteTicks = WRITE_TICKS
) (
  // Clock and reset
  input wire logic       clk_sys,
  input wire logic       reset_n,
  // Register strobes
  input wire logic       addrWrite,
  input wire logic       dataWrite,
  input wire logic       ctrlWrite,
  input wire logic [7:0] ctrlWdata,
  // Register state
  input wire logic [7:0] nvmAddr,
  input wire logic [7:0] nvmControl,
  input wire logic       busy,
  // Interrupts
  input wire logic       nvmIrqEnable,
  input wire logic       mfIrqEnable,
  input wire logic       stackFull,
  input wire logic       globalIrqSet,
  input wire logic       nvmIrqFlagClear,
  input wire logic       irqAck,
  input wire logic       nvmIrqFlag,
  input wire logic       mfIrqFlag,
  input wire logic       globalIrqEnable,
  input wire logic       irqVector
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  AST_ADDR_TOP: assert property (nvmAddr[7] == 1'b0)
    else $error("Address bit 7 is not zero");
  AST_ADDR_STEP: assert property (
    dataWrite && !addrWrite && !busy && nvmControl[4] |=>
      nvmAddr[6:4] == $past(nvmAddr[6:4]) &&
      nvmAddr[3:0] == (($past(nvmAddr[3:0]) == 4'hF) ? 4'hF : $past(nvmAddr[3:0]) + 4'h1))
    else $error("In-page address did not step or saturate");
  AST_TRIG_REFUSED: assert property (
    ctrlWrite && !busy && !nvmControl[6] && ctrlWdata[5] && !(ctrlWdata[2] && nvmControl[3])
      |=> !nvmControl[5] && !busy)
    else $error("Erase started without enable");
  AST_GO_REFUSED: assert property (
    ctrlWrite && !busy && !nvmControl[3] && ctrlWdata[2] && !(ctrlWdata[5] && nvmControl[6])
      |=> !nvmControl[2] && !busy)
    else $error("Write started without enable");
  // Slow timer ticks pass a synchroniser, so no cycle can end within four clocks.
  AST_ERASE_START: assert property (
    ctrlWrite && !busy && nvmControl[6] && ctrlWdata[6] && ctrlWdata[5]
      |=> busy && nvmControl[5] ##1 busy [*3])
    else $error("Erase did not start or ended too soon");
  AST_ERASE_END: assert property (
    $fell(nvmControl[5]) |-> busy && nvmControl[6] ##1 !nvmControl[6] && !busy)
    else $error("Erase end order wrong");
  AST_PROG_END: assert property (
    $fell(nvmControl[2]) |-> busy && nvmControl[3] ##1 !nvmControl[3] && !busy)
    else $error("Write end order wrong");
  AST_IRQ_SET: assert property ($fell(busy) |-> nvmIrqFlag && mfIrqFlag)
    else $error("Flags not set at cycle end");
  AST_VECTOR: assert property (
    irqVector == (globalIrqEnable && nvmIrqEnable && mfIrqEnable && mfIrqFlag && !stackFull))
    else $error("Vector request wrong");
  AST_ACK: assert property (
    irqAck && !globalIrqSet |=> !globalIrqEnable && (!mfIrqFlag || $fell(busy)) &&
      (nvmIrqFlag || !$past(nvmIrqFlag) || $past(nvmIrqFlagClear)))
    else $error("Service clears wrong flags");
endmodule : dewc_ctrl_props

bind dewc_ctrl dewc_ctrl_props #(.EraseTicks(EraseTicks), .WriteTicks(WriteTicks)) u_props (
  .clk_sys(clk_sys), .reset_n(reset_n), .addrWrite(addrWrite), .dataWrite(dataWrite),
  .ctrlWrite(ctrlWrite), .ctrlWdata(ctrlWdata), .nvmAddr(nvmAddr), .nvmControl(nvmControl),
  .busy(busy), .nvmIrqEnable(nvmIrqEnable), .mfIrqEnable(mfIrqEnable), .stackFull(stackFull),
  .globalIrqSet(globalIrqSet), .nvmIrqFlagClear(nvmIrqFlagClear), .irqAck(irqAck),
  .nvmIrqFlag(nvmIrqFlag), .mfIrqFlag(mfIrqFlag), .globalIrqEnable(globalIrqEnable),
  .irqVector(irqVector));

// file: data_eeprom_erase_write_ctrl_bench.sv
// Self-checking bench for the erase and write controller.
module data_eeprom_erase_write_ctrl_bench
  import dewc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 1'b0, reset_n = 1'b0, subClk = 1'b0;
  logic addrWrite = 1'b0, dataWrite = 1'b0, ctrlWrite = 1'b0, busy, irqVector;
  logic [7:0] addrWdata = 8'h00, dataWdata = 8'h00, ctrlWdata = 8'h00;
  logic [7:0] nvmAddr, nvmData, nvmControl, readData;
  logic nvmIrqEnable = 1'b0, mfIrqEnable = 1'b0, stackFull = 1'b0, globalIrqSet = 1'b0;
  logic globalIrqClear = 1'b0, nvmIrqFlagClear = 1'b0, irqAck = 1'b0;
  logic nvmIrqFlag, mfIrqFlag, globalIrqEnable;
  logic [ADDR_W-1:0] readAddr = 7'h00;
  logic [6:0]        addrPick;
  logic [7:0]        memModel [MEM_BYTES];
  logic [7:0]        bufModel [PAGE_BYTES];
  bit                tagModel [PAGE_BYTES];
  logic [7:0]        refCtl [4] = '{8'h04, 8'h20, 8'h0C, 8'h60};
  logic [7:0]        refExp [4] = '{8'h00, 8'h00, 8'h08, 8'h40};
  int errors = 0;
  int checks = 0;

  always #5 clk_sys = ~clk_sys;
  // The slow timer clock runs free with a period unrelated to the system clock.
  always #37 subClk = ~subClk;

  // Short cycle lengths keep the run brief; the synchroniser still adds its delay.
  dewc_ctrl #(.EraseTicks(8'h02), .WriteTicks(8'h03)) dut (
    .clk_sys(clk_sys), .reset_n(reset_n), .addrWrite(addrWrite), .addrWdata(addrWdata),
    .dataWrite(dataWrite), .dataWdata(dataWdata), .ctrlWrite(ctrlWrite), .ctrlWdata(ctrlWdata),
    .nvmAddr(nvmAddr), .nvmData(nvmData), .nvmControl(nvmControl), .busy(busy),
    .subClk(subClk), .nvmIrqEnable(nvmIrqEnable), .mfIrqEnable(mfIrqEnable),
    .stackFull(stackFull), .globalIrqSet(globalIrqSet), .globalIrqClear(globalIrqClear),
    .nvmIrqFlagClear(nvmIrqFlagClear), .irqAck(irqAck), .nvmIrqFlag(nvmIrqFlag),
    .mfIrqFlag(mfIrqFlag), .globalIrqEnable(globalIrqEnable), .irqVector(irqVector),
    .readAddr(readAddr), .readData(readData));

  task automatic finish_test();
    $display("Checks %0d, errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic wr(input int sel, input logic [7:0] val);
    @(posedge clk_sys);
    addrWrite <= (sel == 0);
    dataWrite <= (sel == 1);
    ctrlWrite <= (sel == 2);
    addrWdata <= val;
    dataWdata <= val;
    ctrlWdata <= val;
  endtask : wr

  task automatic idle();
    @(posedge clk_sys);
    addrWrite <= 1'b0;
    dataWrite <= 1'b0;
    ctrlWrite <= 1'b0;
    #1;
  endtask : idle

  task automatic irq_pulse(input logic [3:0] m);
    @(posedge clk_sys);
    {irqAck, nvmIrqFlagClear, globalIrqClear, globalIrqSet} <= m;
    @(posedge clk_sys);
    {irqAck, nvmIrqFlagClear, globalIrqClear, globalIrqSet} <= 4'h0;
    #1;
  endtask : irq_pulse

  // Interrupts are masked around the launch so nothing splits the two writes.
  task automatic run_cycle(input logic [7:0] en, input logic [7:0] go);
    int n;
    irq_pulse(4'hE);
    wr(2, en);
    wr(2, go);
    idle();
    chk({7'h00, busy}, 8'h01, "busy after launch");
    irq_pulse(4'h1);
    n = 0;
    while (busy === 1'b1 && n < 1000) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n >= 1000) begin
      errors++;
      $display("CHECK FAILED at %0t: cycle never ended", $time);
      finish_test();
    end
    chk(nvmControl, en & 8'h10, "control after cycle");
    chk({6'h00, nvmIrqFlag, mfIrqFlag}, 8'h03, "flags after cycle");
  endtask : run_cycle

  task automatic page_load(input logic [6:0] start, input int n);
    logic [7:0] d;
    logic [3:0] off;
    bit full;
    wr(0, {1'b0, start});
    off = start[3:0];
    full = 1'b0;
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom());
      wr(1, d);
      if (!full) begin
        bufModel[off] = d;
        tagModel[off] = 1'b1;
        full = (off == 4'hF);
        off = full ? off : off + 4'h1;
      end
    end
    idle();
    chk(nvmAddr, {1'b0, start[6:4], off}, "address after load");
  endtask : page_load

  task automatic commit(input logic [2:0] pg, input bit erase);
    for (int i = 0; i < PAGE_BYTES; i++) begin
      if (tagModel[i]) begin
        memModel[{pg, 4'(i)}] = erase ? ERASED_VALUE : bufModel[i];
      end
      tagModel[i] = 1'b0;
    end
  endtask : commit

  task automatic chk_mem(input logic [6:0] a);
    @(posedge clk_sys);
    readAddr <= a;
    @(posedge clk_sys);
    #1;
    chk(readData, memModel[a], "array content");
  endtask : chk_mem

  task automatic chk_page(input logic [2:0] pg);
    for (int i = 0; i < PAGE_BYTES; i++) begin
      chk_mem({pg, 4'(i)});
    end
  endtask : chk_page

  initial begin
    void'($urandom(18897));
    repeat (4) @(posedge clk_sys);
    reset_n <= 1'b1;
    wr(0, 8'hFF);
    idle();
    chk(nvmAddr, 8'h7F, "address bit 7");
    for (int k = 0; k < 4; k++) begin
      wr(2, refCtl[k]);
      idle();
      chk(nvmControl, refExp[k], "refused start");
      chk({7'h00, busy}, 8'h00, "no cycle");
      wr(2, 8'h00);
    end
    wr(2, 8'h10);
    page_load(7'h20, 16);
    run_cycle(8'h50, 8'h70);
    commit(3'h2, 1'b1);
    chk_page(3'h2);
    page_load(7'h20, 17);
    run_cycle(8'h18, 8'h1C);
    commit(3'h2, 1'b0);
    chk_page(3'h2);
    page_load(7'h22, 3);
    @(posedge clk_sys);
    reset_n <= 1'b0;
    @(posedge clk_sys);
    reset_n <= 1'b1;
    tagModel = '{default: 1'b0};
    wr(0, 8'h20);
    wr(2, 8'h10);
    run_cycle(8'h50, 8'h70);
    chk_page(3'h2);
    page_load(7'h23, 5);
    run_cycle(8'h50, 8'h70);
    commit(3'h2, 1'b1);
    chk_page(3'h2);
    page_load(7'h25, 4);
    wr(2, 8'h18);
    wr(2, 8'h10);
    tagModel = '{default: 1'b0};
    run_cycle(8'h18, 8'h1C);
    chk_page(3'h2);
    page_load(7'h28, 4);
    wr(2, 8'h50);
    wr(2, 8'h10);
    tagModel = '{default: 1'b0};
    run_cycle(8'h50, 8'h70);
    chk_page(3'h2);
    wr(2, 8'h00);
    for (int k = 0; k < 6; k++) begin
      addrPick = 7'($urandom_range(47, 32));
      memModel[addrPick] = 8'($urandom());
      wr(0, {1'b0, addrPick});
      wr(1, memModel[addrPick]);
      run_cycle(8'h08, 8'h0C);
      chk(nvmData, memModel[addrPick], "data register");
      chk_mem(addrPick);
    end
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_sys);
      {nvmIrqEnable, mfIrqEnable, stackFull} <= 3'(k);
      @(posedge clk_sys);
      #1;
      chk({7'h00, irqVector}, {7'h00, k[2] & k[1] & ~k[0]}, "vector");
    end
    irq_pulse(4'h8);
    chk({5'h00, nvmIrqFlag, mfIrqFlag, globalIrqEnable}, 8'h04, "service");
    irq_pulse(4'h4);
    chk({7'h00, nvmIrqFlag}, 8'h00, "flag clear");
    finish_test();
  end
endmodule : data_eeprom_erase_write_ctrl_bench
